/* common/eirq_params.svh */
// Constants for the endpoint interrupt request port.
`ifndef EIRQ_PARAMS_SVH
`define EIRQ_PARAMS_SVH
`define EIRQ_ADDR_CTRL     12'h000
`define EIRQ_ADDR_STATUS   12'h004
`define EIRQ_ADDR_MSI_LO   12'h008
`define EIRQ_ADDR_MSI_HI   12'h00c
`define EIRQ_ADDR_MSI_DATA 12'h010
`define EIRQ_ADDR_IRQ_STAT 12'h014
`define EIRQ_ADDR_IRQ_MASK 12'h018
`define EIRQ_CTRL_MSI_EN   0
`define EIRQ_CTRL_MSIX_EN  1
`define EIRQ_CTRL_INT_DIS  10
`define EIRQ_CTRL_MME_LSB  4
`define EIRQ_EV_ASSERT     0
`define EIRQ_EV_DEASSERT   1
`define EIRQ_EV_MSI        2
`define EIRQ_EV_BLOCKED    3
`define EIRQ_CTRL_RESET    32'h0000_0000
`endif

/* common/eirq_pkg.sv */
// Types for the endpoint interrupt request port.
package eirq_pkg;
  typedef enum logic [1:0] {MSG_NONE, MSG_ASSERT, MSG_DEASSERT, MSG_MSI} eirq_msg_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_SEND} eirq_state_t;
endpackage

/* rtl/eirq_port.sv */
// Interrupt request port: user request handshake, message generation, AXI4-Lite registers.
// Contract
// [R1] User requests INTA with vector 00h only.
// [R2] Accept pulse on assert; user then drops request.
// [R3] Assert message only when interrupt-disable is zero.
// [R4] User deasserts with legacy level low.
// [R5] Accept deassert, then send deassert message.
// [R6] User places vector when multi-vector MSI enabled.
// [R7] Accept MSI request and send one write.
// [R8] MSI address and data from software fields.
// [R9] 64-bit form only if upper address nonzero.
// [R10] Multi-vector needs nonzero enable and capability.
// [R11] Replaced bits: lesser of capable and enabled.
// [R12] Mask vector bits not granted by enable.
// [R13] Enable 000b one vector, 101b thirty-two.
// [R14] Per-vector mask is never checked here.
// [R15] User builds MSI-X writes when enable high.
// [R16] MSI enable selects MSI; status shows it.
// [R17] Command bit 10 blocks legacy requests; the code blocks only assert requests, and deassert messages are still sent.
// [R18] User holds request stable, one outstanding.
`timescale 1ns/1ps
`include "eirq_params.svh"
module eirq_port #(
  parameter logic [2:0] MM_CAPABLE = 3'h5
) (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire logic                 IRQ_REQ_I,
  input  wire logic                 IRQ_ASSERT_I,
  input  wire logic [7:0]           IRQ_VECTOR_IN_I,
  output logic                      IRQ_RDY_O,
  output logic [2:0]                IRQ_MMENABLE_O,
  output logic                      IRQ_MSIENABLE_O,
  output logic                      IRQ_MSIXENABLE_O,
  output logic                      MSG_VALID_O,
  output eirq_pkg::eirq_msg_t       MSG_KIND_O,
  output logic                      MSG_ADDR64_O,
  output logic [63:0]               MSG_ADDR_O,
  output logic [31:0]               MSG_DATA_O,
  output logic                      IRQ_O,
  input  wire logic [11:0]          S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [11:0]          S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY
);
  import eirq_pkg::*;

  if (MM_CAPABLE > 3'h5)
  begin
    $error("Multiple message capable above 32 vectors.");
  end

  logic [31:0] ctrl_r;
  logic [31:0] msi_lo_r;
  logic [31:0] msi_hi_r;
  logic [31:0] msi_data_r;
  logic [3:0]  ists_r;
  logic [3:0]  imask_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [1:0]  bresp_r;
  eirq_state_t state_r;
  logic        rdy_r;
  logic        msg_valid_r;
  eirq_msg_t   msg_kind_r;
  logic        addr64_r;
  logic [63:0] addr_r;
  logic [31:0] data_r;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic [7:0] vec_mask(input logic [2:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (i < int'(n))
        m[i] = 1'b1;
    end
    return m;
  endfunction

  // Configuration fields and derived modes.
  wire       msi_en   = ctrl_r[`EIRQ_CTRL_MSI_EN];                              // [R16]
  wire       msix_en  = ctrl_r[`EIRQ_CTRL_MSIX_EN];                             // [R15]
  wire       int_dis  = ctrl_r[`EIRQ_CTRL_INT_DIS];                             // [R17]
  wire [2:0] mme      = ctrl_r[`EIRQ_CTRL_MME_LSB +: 3];
  wire [2:0] mm_grant = (mme < MM_CAPABLE) ? mme : MM_CAPABLE;                  // [R10] [R11]
  wire [7:0] vmask    = vec_mask(mm_grant);                                     // [R12] [R13]
  wire [31:0] msi_payload = (msi_data_r & ~{24'h000000, vmask})
                          | {24'h000000, IRQ_VECTOR_IN_I & vmask};              // [R8] [R12]
  wire        hi_nz    = (msi_hi_r != 32'h0000_0000);                           // [R9]

  // A request is taken in idle; the user holds it stable until acceptance.
  wire take = (state_r == ST_IDLE) && IRQ_REQ_I;                                // [R18]
  wire legacy_block = !msi_en && IRQ_ASSERT_I && int_dis;                       // [R3] [R17]

  // Request handshake: accept in one cycle, send the message after the user drops.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state_r     <= ST_IDLE;
      rdy_r       <= 1'b0;
      msg_valid_r <= 1'b0;
      msg_kind_r  <= MSG_NONE;
      addr64_r    <= 1'b0;
      addr_r      <= 64'h0;
      data_r      <= 32'h0;
    end
    else
    begin
      rdy_r       <= take;                                                      // [R2] [R5] [R7]
      msg_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (take)
          begin
            state_r  <= ST_ACK;
            addr64_r <= msi_en && hi_nz;                                        // [R9]
            addr_r   <= {msi_hi_r, msi_lo_r};                                   // [R8]
            data_r   <= msi_en ? msi_payload : 32'h0;                           // [R14]
            if (msi_en)
              msg_kind_r <= MSG_MSI;                                            // [R16]
            else if (legacy_block)
              msg_kind_r <= MSG_NONE;                                           // [R3]
            else if (IRQ_ASSERT_I)
              msg_kind_r <= MSG_ASSERT;
            else
              msg_kind_r <= MSG_DEASSERT;                                       // [R5]
          end
        ST_ACK:
          state_r <= ST_SEND;
        ST_SEND:
        begin
          msg_valid_r <= (msg_kind_r != MSG_NONE);                              // [R3] [R5] [R7]
          state_r     <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Events for the interrupt status register.
  wire [3:0] ev;
  assign ev[`EIRQ_EV_ASSERT]   = msg_valid_r && (msg_kind_r == MSG_ASSERT);
  assign ev[`EIRQ_EV_DEASSERT] = msg_valid_r && (msg_kind_r == MSG_DEASSERT);
  assign ev[`EIRQ_EV_MSI]      = msg_valid_r && (msg_kind_r == MSG_MSI);
  assign ev[`EIRQ_EV_BLOCKED]  = (state_r == ST_SEND) && (msg_kind_r == MSG_NONE);

  // AXI4-Lite slave.
  wire aw_ok  = aw_got_r || S_AXI_AWVALID;
  wire w_ok   = w_got_r || S_AXI_WVALID;
  wire do_wr  = aw_ok && w_ok && !bvalid_r;
  wire [11:0] wa = aw_got_r ? awaddr_r : S_AXI_AWADDR;
  wire [31:0] wd = w_got_r ? wdata_r : S_AXI_WDATA;
  wire [3:0]  ws = w_got_r ? wstrb_r : S_AXI_WSTRB;
  wire wr_ctrl = do_wr && (wa == `EIRQ_ADDR_CTRL);
  wire wr_lo   = do_wr && (wa == `EIRQ_ADDR_MSI_LO);
  wire wr_hi   = do_wr && (wa == `EIRQ_ADDR_MSI_HI);
  wire wr_data = do_wr && (wa == `EIRQ_ADDR_MSI_DATA);
  wire wr_ists = do_wr && (wa == `EIRQ_ADDR_IRQ_STAT);
  wire wr_mask = do_wr && (wa == `EIRQ_ADDR_IRQ_MASK);
  wire wr_hit  = wr_ctrl || wr_lo || wr_hi || wr_data || wr_ists || wr_mask
               || (wa == `EIRQ_ADDR_STATUS);
  wire do_rd  = S_AXI_ARVALID && !rvalid_r;
  wire [31:0] status_w = {23'h0, mm_grant, 3'h0, state_r != ST_IDLE, msix_en, msi_en};
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    if (S_AXI_ARADDR == `EIRQ_ADDR_CTRL)          rd_mux = ctrl_r;
    else if (S_AXI_ARADDR == `EIRQ_ADDR_STATUS)   rd_mux = status_w;
    else if (S_AXI_ARADDR == `EIRQ_ADDR_MSI_LO)   rd_mux = msi_lo_r;
    else if (S_AXI_ARADDR == `EIRQ_ADDR_MSI_HI)   rd_mux = msi_hi_r;
    else if (S_AXI_ARADDR == `EIRQ_ADDR_MSI_DATA) rd_mux = msi_data_r;
    else if (S_AXI_ARADDR == `EIRQ_ADDR_IRQ_STAT) rd_mux = {28'h0, ists_r};
    else if (S_AXI_ARADDR == `EIRQ_ADDR_IRQ_MASK) rd_mux = {28'h0, imask_r};
    else
    begin
      rd_mux = 32'h0;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= 2'b00;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        awaddr_r <= S_AXI_AWADDR;
        aw_got_r <= !do_wr;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
        w_got_r <= !do_wr;
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? 2'b00 : 2'b10;
      end
      else if (S_AXI_BREADY)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= 2'b00;
    end
    else if (do_rd)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? 2'b00 : 2'b10;
    end
    else if (S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end

  // Configuration registers; status bits set wins over write-one-to-clear.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ctrl_r     <= `EIRQ_CTRL_RESET;
      msi_lo_r   <= 32'h0;
      msi_hi_r   <= 32'h0;
      msi_data_r <= 32'h0;
      ists_r     <= 4'h0;
      imask_r    <= 4'h0;
    end
    else
    begin
      if (wr_ctrl) ctrl_r     <= merge_bytes(ctrl_r, wd, ws);
      if (wr_lo)   msi_lo_r   <= merge_bytes(msi_lo_r, wd, ws) & 32'hffff_fffc;
      if (wr_hi)   msi_hi_r   <= merge_bytes(msi_hi_r, wd, ws);
      if (wr_data) msi_data_r <= merge_bytes(msi_data_r, wd, ws);
      if (wr_mask && ws[0]) imask_r <= wd[3:0];
      ists_r <= (ists_r & ~((wr_ists && ws[0]) ? wd[3:0] : 4'h0)) | ev;
    end
  end

  assign S_AXI_AWREADY    = !aw_got_r && !bvalid_r;
  assign S_AXI_WREADY     = !w_got_r && !bvalid_r;
  assign S_AXI_BVALID     = bvalid_r;
  assign S_AXI_BRESP      = bresp_r;
  assign S_AXI_ARREADY    = !rvalid_r;
  assign S_AXI_RVALID     = rvalid_r;
  assign S_AXI_RDATA      = rdata_r;
  assign S_AXI_RRESP      = rresp_r;
  assign IRQ_RDY_O        = rdy_r;
  assign IRQ_MMENABLE_O   = mm_grant;                                           // [R11]
  assign IRQ_MSIENABLE_O  = msi_en;                                             // [R16]
  assign IRQ_MSIXENABLE_O = msix_en;                                            // [R15]
  assign MSG_VALID_O      = msg_valid_r;
  assign MSG_KIND_O       = msg_kind_r;
  assign MSG_ADDR64_O     = addr64_r;
  assign MSG_ADDR_O       = addr_r;
  assign MSG_DATA_O       = data_r;
  assign IRQ_O            = |(ists_r & imask_r);

  sequence accept_s;
    IRQ_RDY_O;
  endsequence
  sequence send_s;
    ##2 MSG_VALID_O;
  endsequence

  accept_once_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R2]
    IRQ_RDY_O |=> !IRQ_RDY_O)
    else $error("Accept pulse longer than one cycle.");
  accept_cause_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R7]
    IRQ_RDY_O |-> $past(IRQ_REQ_I) && ($past(state_r) == ST_IDLE))
    else $error("Accept without a request.");
  msi_send_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R7]
    (accept_s ##0 (MSG_KIND_O == MSG_MSI)) |-> send_s)
    else $error("MSI write not sent after acceptance.");
  blocked_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R3]
    MSG_VALID_O && MSG_KIND_O == MSG_ASSERT |-> !$past(int_dis, 3))
    else $error("Assert message sent while disabled.");
  deassert_send_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R5]
    (IRQ_REQ_I && !IRQ_ASSERT_I && !msi_en && take) |-> ##3 MSG_VALID_O)
    else $error("Deassert message missing.");
  addr_form_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R9]
    MSG_VALID_O && MSG_KIND_O == MSG_MSI |-> MSG_ADDR64_O == (MSG_ADDR_O[63:32] != 32'h0))
    else $error("Wrong MSI address form.");
  vec_mask_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R12]
    MSG_VALID_O |-> (MSG_DATA_O[7:0] & ~vmask) == (msi_data_r[7:0] & ~vmask)
                    || MSG_KIND_O != MSG_MSI || $changed(msi_data_r))
    else $error("Ungranted vector bits reached the payload.");
  grant_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [R11]
    IRQ_MMENABLE_O <= MM_CAPABLE && IRQ_MMENABLE_O <= mme)
    else $error("Granted vector count too large.");
endmodule

/* testbench/eirq_user.sv */
// User application model that raises interrupt requests.
`timescale 1ns/1ps
module eirq_user (
  input  wire logic       clk_i,
  input  wire logic       rdy_i,
  output logic            req_o,
  output logic            assert_o,
  output logic [7:0]      vector_o
);
  initial
  begin
    req_o = 1'b0;
    assert_o = 1'b0;
    vector_o = 8'h00;
  end
  // Holds the request until acceptance, then drops it on the next cycle.
  task automatic send(input logic lvl, input logic [7:0] vec, output logic ok);
    int i;
    begin
      ok = 1'b0;
      req_o <= 1'b1;
      assert_o <= lvl;
      vector_o <= vec;
      for (i = 0; i < 50 && !ok; i++)
      begin
        @(posedge clk_i);
        ok = (rdy_i === 1'b1);
      end
      req_o <= 1'b0;
      assert_o <= ~lvl;
      vector_o <= ~vec;
    end
  endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the interrupt request port.
`timescale 1ns/1ps
`include "eirq_params.svh"
module tb_top;
  import eirq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rdy, req, lvl, msie, msixe, mv, a64, irq;
  logic [7:0] vec;
  logic [2:0] mme_o;
  eirq_msg_t kind, m_kind;
  logic [63:0] addr, m_addr;
  logic [31:0] data, m_data, wd = 32'h0, rdat, rd;
  logic m_a64, awv = 1'b0, wv = 1'b0, bv, brdy = 1'b0, arv = 1'b0, rv, rrdy = 1'b0;
  logic awr, wr_r, arr, ok;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [1:0] bresp, rresp, rs, wrs;
  int num_errors = 0, cmp_count = 0, n_msg = 0, k, base;
  logic [31:0] md, lo, hi;
  logic [7:0] v;
  logic [2:0] mm, g;
  always #5 clk = ~clk;
  eirq_port eirq_port_inst (.CLK_I(clk), .RST_I(rst), .IRQ_REQ_I(req), .IRQ_ASSERT_I(lvl),
    .IRQ_VECTOR_IN_I(vec), .IRQ_RDY_O(rdy), .IRQ_MMENABLE_O(mme_o), .IRQ_MSIENABLE_O(msie),
    .IRQ_MSIXENABLE_O(msixe), .MSG_VALID_O(mv), .MSG_KIND_O(kind), .MSG_ADDR64_O(a64),
    .MSG_ADDR_O(addr), .MSG_DATA_O(data), .IRQ_O(irq), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy));
  eirq_user eirq_user_inst (.clk_i(clk), .rdy_i(rdy), .req_o(req), .assert_o(lvl),
    .vector_o(vec));
  always @(posedge clk)
    if (mv === 1'b1)
    begin
      n_msg <= n_msg + 1;
      m_kind <= kind;
      m_a64 <= a64;
      m_addr <= addr;
      m_data <= data;
    end
  task results;
    begin
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tmo(input int i);
    begin
      if (i >= 100)
      begin
        num_errors++;
        results;
      end
    end
  endtask
  task axw(input logic [11:0] a, input logic [31:0] d);
    int i;
    bit ta, tw;
    begin
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      ta = 0;
      tw = 0;
      for (i = 0; i < 100 && !(ta && tw); i++)
      begin
        @(posedge clk);
        if (awv && awr === 1'b1)
        begin
          ta = 1;
          awv <= 1'b0;
        end
        if (wv && wr_r === 1'b1)
        begin
          tw = 1;
          wv <= 1'b0;
        end
      end
      tmo(i);
      brdy <= 1'b1;
      for (i = 0; i < 100; i++)
      begin
        @(posedge clk);
        if (bv === 1'b1) break;
      end
      tmo(i);
      wrs = bresp;
      brdy <= 1'b0;
    end
  endtask
  task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    begin
      ara <= a;
      arv <= 1'b1;
      for (i = 0; i < 100; i++)
      begin
        @(posedge clk);
        if (arr === 1'b1) break;
      end
      tmo(i);
      arv <= 1'b0;
      rrdy <= 1'b1;
      for (i = 0; i < 100; i++)
      begin
        @(posedge clk);
        if (rv === 1'b1) break;
      end
      tmo(i);
      d = rdat;
      r = rresp;
      rrdy <= 1'b0;
    end
  endtask
  function automatic logic [31:0] exp_data(logic [31:0] m, logic [7:0] u, logic [2:0] n);
    logic [31:0] msk;
    begin
      msk = (32'h1 << n) - 32'h1;
      return (m & ~msk) | ({24'h0, u} & msk);
    end
  endfunction
  task irq_req(input logic l, input logic [7:0] u, input int add);
    begin
      base = n_msg;
      eirq_user_inst.send(l, u, ok);
      chk(ok, 1'b1);
      if (ok !== 1'b1)
        results;
      repeat (3) @(posedge clk);
      chk(n_msg, base + add);
    end
  endtask
  initial
  begin
    void'($urandom(32'h1ff1ecf0));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(`EIRQ_ADDR_CTRL, rd, rs);
    chk(rd, `EIRQ_CTRL_RESET);
    axr(12'h0fc, rd, rs);
    chk(rs, 2'h2);
    axw(12'h0fc, 32'h0);
    chk(wrs, 2'h2);
    axw(`EIRQ_ADDR_IRQ_MASK, 32'hf);
    chk(wrs, 2'h0);
    irq_req(1'b1, 8'h00, 1);
    chk(m_kind, MSG_ASSERT);
    chk(irq, 1'b1);
    axw(`EIRQ_ADDR_IRQ_STAT, 32'hf);
    chk(irq, 1'b0);
    irq_req(1'b0, 8'h00, 1);
    chk(m_kind, MSG_DEASSERT);
    axw(`EIRQ_ADDR_CTRL, 32'h400);
    irq_req(1'b1, 8'h00, 0);
    axr(`EIRQ_ADDR_IRQ_STAT, rd, rs);
    chk(rd[3], 1'b1);
    $display("legacy test done");
    axw(`EIRQ_ADDR_CTRL, 32'h2);
    chk({msixe, msie}, 2'h2);
    for (k = 0; k < 8; k++)
    begin
      mm = 3'($urandom);
      if (k == 7)
        mm = 3'h7;
      g = (mm < 3'h5) ? mm : 3'h5;
      md = $urandom;
      lo = $urandom & 32'hffff_fffc;
      hi = k[0] ? $urandom : 32'h0;
      v = 8'($urandom);
      if (!k[1]) v = v & ((8'h1 << g) - 8'h1);
      axw(`EIRQ_ADDR_MSI_LO, lo);
      axw(`EIRQ_ADDR_MSI_HI, hi);
      axw(`EIRQ_ADDR_MSI_DATA, md);
      axw(`EIRQ_ADDR_CTRL, {25'h0, mm, 4'h1});
      chk({msie, mme_o}, {1'b1, g});
      irq_req(1'b0, v, 1);
      chk(m_kind, MSG_MSI);
      chk(m_a64, hi != 32'h0);
      chk(m_addr, {hi, lo});
      chk(m_data, exp_data(md, v, g));
    end
    $display("msi test done");
    results;
  end
endmodule
